// File: hdl/shbi_pkg.sv
// shared constants and carrier types for the slave host bus interface
package shbi_pkg;
  // internal instruction opcodes
  localparam logic [7:0] SHBI_OP_LOAD_USER_STATUS = 8'h90;
  localparam logic [7:0] SHBI_OP_ENABLE_FLAGS = 8'hA1;
  localparam logic [7:0] SHBI_OP_ENABLE_DMA = 8'hA2;
  // status register field positions
  localparam int SHBI_BIT_OBF = 0;
  localparam int SHBI_BIT_IBF = 1;
  localparam int SHBI_BIT_F0 = 2;
  localparam int SHBI_BIT_F1 = 3;
  localparam int SHBI_USER_LSB = 4;
  localparam int SHBI_USER_MSB = 7;
  // port 2 upper nibble positions (index 0 is port2_bit4)
  localparam int SHBI_P2_OBF = 0;
  localparam int SHBI_P2_IBF = 1;
  localparam int SHBI_P2_DRQ = 2;
  localparam int SHBI_P2_DMA_ACKNOWLEDGE = 3;
  // values after reset
  localparam logic [7:0] SHBI_STATUS_RESET = 8'h00;
  localparam logic [7:0] SHBI_BUFFER_RESET = 8'h00;
  localparam logic [3:0] SHBI_PORT2_RESET = 4'hF;
  localparam logic [3:0] SHBI_USER_RESET = 4'h0;

  // host bus pins as seen by the device
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic command_select;
    logic [7:0] data;
  } shbi_host_in_t;

  // one executed instruction from the internal core
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] acc;
  } shbi_instr_t;
endpackage

// File: hdl/shbi_strobe_edge.sv
// trailing-edge detector for one active-low host strobe
`timescale 1ns/1ps
module shbi_strobe_edge (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // strobe and qualifying select
  input wire logic strobe_n,
  input wire logic selected,
  // strobe in progress and trailing-edge pulse
  output logic active,
  output logic trail
);
  logic active_q;

  // the select is judged while the strobe is low, so a select that drops with
  // the trailing edge still counts
  assign active = ~strobe_n & selected;
  assign trail = active_q & ~active;

  // remember whether a selected strobe was in progress last cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active;
    end
  end
endmodule

// File: hdl/shbi_host_port.sv
// device side of the slave host bus interface: buffers, status, flag and dma pins
// What this block does
// - separate input buffer from master and output buffer to master.
// - status bits: output full, input full, flag zero, flag one, user nibble.
// - load user status copies accumulator bits 4-7, bits 0-3 kept.
// - load user status is one-byte opcode 90H, single cycle.
// - strobes edge-triggered; flags and interrupt change after trailing edge.
// - port2 bits 4,5 are port pins until enable-flags runs.
// - flag mode: bit4 latch 1 shows output-full, 0 holds low.
// - flag mode: bit5 latch 1 shows inverted input-full, 0 holds low.
// - bits 6,7 port pins; after enable-dma, writing bit6 one raises request.
// - request drops at a read or write trailing edge with acknowledge still low, or enable-dma again.
// - in dma mode bit7 is acknowledge, selecting data buffers like chip select.
// - reset clears status and returns flag and dma pins to port use.
`timescale 1ns/1ps
module shbi_host_port (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // master data bus side
  input wire shbi_pkg::shbi_host_in_t host_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  // internal core: instruction execution
  input wire shbi_pkg::shbi_instr_t instr,
  // internal core: buffer and flag access
  input wire logic in_buf_rd,
  input wire logic out_buf_wr,
  input wire logic [7:0] out_buf_data,
  input wire logic flag_wr,
  input wire logic flag_f0,
  input wire logic flag_f1,
  output logic [7:0] in_buf_data,
  output logic [7:0] status,
  output logic ibf_int,
  // port 2 upper nibble (index 0 is port2_bit4)
  input wire logic port2_wr,
  input wire logic [3:0] port2_wdata,
  input wire logic port2_bit7_in,
  output logic [3:0] port2_upper
);
  logic [7:0] in_buf_q, in_buf_d;
  logic [7:0] out_buf_q, out_buf_d;
  logic ibf_q, ibf_d, obf_q, obf_d, f0_q, f0_d, f1_q, f1_d;
  logic [3:0] user_q, user_d;
  logic flags_mode_q, dma_mode_q, drq_q, drq_d;
  logic [3:0] port2_latch_q, port2_pins_d, port2_upper_q;
  logic [7:0] wr_data_q, rd_data_q;
  logic wr_cmd_q, rd_cmd_q;
  logic dma_ack, selected, cmd_eff;
  logic rd_active, rd_trail, wr_active, wr_trail;
  logic op_load_status, op_en_flags, op_en_dma, data_read_done, dma_acknowledge_done;

  // one-shot instruction decode, shared by several registers
  function automatic logic is_op(input shbi_pkg::shbi_instr_t i, input logic [7:0] code);
    is_op = i.valid && (i.opcode == code);
  endfunction

  // instruction decode and bus selection
  assign op_load_status = is_op(instr, shbi_pkg::SHBI_OP_LOAD_USER_STATUS);
  assign op_en_flags = is_op(instr, shbi_pkg::SHBI_OP_ENABLE_FLAGS);
  assign op_en_dma = is_op(instr, shbi_pkg::SHBI_OP_ENABLE_DMA);
  assign dma_ack = dma_mode_q & ~port2_bit7_in;
  assign selected = ~host_in.cs_n | dma_ack;
  // an acknowledged dma cycle always addresses the data buffers
  assign cmd_eff = host_in.command_select & ~dma_ack;

  // read and write strobes, both acting on their trailing edge
  shbi_strobe_edge u_rd_edge (
    .clk(clk),
    .reset(reset),
    .strobe_n(host_in.rd_n),
    .selected(selected),
    .active(rd_active),
    .trail(rd_trail)
  );
  shbi_strobe_edge u_wr_edge (
    .clk(clk),
    .reset(reset),
    .strobe_n(host_in.wr_n),
    .selected(selected),
    .active(wr_active),
    .trail(wr_trail)
  );

  // capture bus while strobes are low; the last value before the edge is used
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_data_q <= shbi_pkg::SHBI_BUFFER_RESET;
      wr_cmd_q <= 1'b0;
      rd_cmd_q <= 1'b0;
      rd_data_q <= shbi_pkg::SHBI_BUFFER_RESET;
    end else begin
      if (wr_active) begin
        wr_data_q <= host_in.data;
        wr_cmd_q <= cmd_eff;
      end
      if (rd_active) begin
        rd_cmd_q <= cmd_eff;
      end
      rd_data_q <= cmd_eff ? status : out_buf_q;
    end
  end

  assign data_read_done = rd_trail & ~rd_cmd_q;
  assign dma_acknowledge_done = dma_ack & (rd_trail | wr_trail);

  // buffer and flag next values; hardware set wins over any clear
  assign in_buf_d = wr_trail ? wr_data_q : in_buf_q;
  assign out_buf_d = out_buf_wr ? out_buf_data : out_buf_q;
  assign ibf_d = wr_trail | (ibf_q & ~in_buf_rd);
  assign obf_d = out_buf_wr | (obf_q & ~data_read_done);
  assign f0_d = flag_wr ? flag_f0 : f0_q;
  // a master write records whether the byte was a command
  assign f1_d = wr_trail ? wr_cmd_q : (flag_wr ? flag_f1 : f1_q);
  assign user_d = op_load_status ? instr.acc[shbi_pkg::SHBI_USER_MSB:shbi_pkg::SHBI_USER_LSB]
                                 : user_q;
  // a fresh request write wins over a same-cycle acknowledge
  assign drq_d = (dma_mode_q & port2_wr & port2_wdata[shbi_pkg::SHBI_P2_DRQ])
               | (drq_q & ~dma_acknowledge_done & ~op_en_dma);

  // status and buffer registers
  always_ff @(posedge clk) begin
    if (reset) begin
      in_buf_q <= shbi_pkg::SHBI_BUFFER_RESET;
      out_buf_q <= shbi_pkg::SHBI_BUFFER_RESET;
      ibf_q <= shbi_pkg::SHBI_STATUS_RESET[shbi_pkg::SHBI_BIT_IBF];
      obf_q <= shbi_pkg::SHBI_STATUS_RESET[shbi_pkg::SHBI_BIT_OBF];
      f0_q <= shbi_pkg::SHBI_STATUS_RESET[shbi_pkg::SHBI_BIT_F0];
      f1_q <= shbi_pkg::SHBI_STATUS_RESET[shbi_pkg::SHBI_BIT_F1];
      user_q <= shbi_pkg::SHBI_USER_RESET;
    end else begin
      in_buf_q <= in_buf_d;
      out_buf_q <= out_buf_d;
      ibf_q <= ibf_d;
      obf_q <= obf_d;
      f0_q <= f0_d;
      f1_q <= f1_d;
      user_q <= user_d;
    end
  end

  // pin modes, port latch and dma request
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_mode_q <= 1'b0;
      dma_mode_q <= 1'b0;
      drq_q <= 1'b0;
      port2_latch_q <= shbi_pkg::SHBI_PORT2_RESET;
      port2_upper_q <= shbi_pkg::SHBI_PORT2_RESET;
    end else begin
      if (op_en_flags) begin
        flags_mode_q <= 1'b1;
      end
      if (op_en_dma) begin
        dma_mode_q <= 1'b1;
      end
      drq_q <= drq_d;
      if (port2_wr) begin
        port2_latch_q <= port2_wdata;
      end
      port2_upper_q <= port2_pins_d;
    end
  end

  // pin functions; the bit7 acknowledge pin floats high as an input in dma mode
  assign port2_pins_d[shbi_pkg::SHBI_P2_OBF] = flags_mode_q
    ? (port2_latch_q[shbi_pkg::SHBI_P2_OBF] & obf_q)
    : port2_latch_q[shbi_pkg::SHBI_P2_OBF];
  assign port2_pins_d[shbi_pkg::SHBI_P2_IBF] = flags_mode_q
    ? (port2_latch_q[shbi_pkg::SHBI_P2_IBF] & ~ibf_q)
    : port2_latch_q[shbi_pkg::SHBI_P2_IBF];
  assign port2_pins_d[shbi_pkg::SHBI_P2_DRQ] = dma_mode_q ? drq_q
    : port2_latch_q[shbi_pkg::SHBI_P2_DRQ];
  assign port2_pins_d[shbi_pkg::SHBI_P2_DMA_ACKNOWLEDGE] = dma_mode_q ? 1'b1
    : port2_latch_q[shbi_pkg::SHBI_P2_DMA_ACKNOWLEDGE];

  // outputs; the bus is driven for the whole selected read strobe
  assign status = {user_q, f1_q, f0_q, ibf_q, obf_q};
  assign host_data_out = rd_data_q;
  assign host_data_oe_n = ~rd_active;
  assign in_buf_data = in_buf_q;
  assign ibf_int = wr_trail;
  assign port2_upper = port2_upper_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence load_status_seq;
    op_load_status ##0 !wr_trail;
  endsequence
  sequence write_done_seq;
    wr_trail ##0 !in_buf_rd;
  endsequence

  // flag zero may still be written by the core in the same cycle as a status load
  user_nibble_load_a: assert property (load_status_seq |=>
    status[7:4] == $past(instr.acc[7:4])
    && status[2] == ($past(flag_wr) ? $past(flag_f0) : $past(status[2])))
    else $error("user status nibble not loaded from accumulator");
  ibf_set_write_a: assert property (write_done_seq |=> ibf_q && in_buf_q == $past(wr_data_q))
    else $error("input full or input buffer wrong after master write");
  ibf_edge_only_a: assert property (!ibf_q ##1 ibf_q |-> $past(wr_trail))
    else $error("input full rose without a write trailing edge");
  obf_read_clear_a: assert property (obf_q && data_read_done && !out_buf_wr |=> !obf_q)
    else $error("output full not cleared by master data read");
  // a one-cycle strobe must still see the status byte on the registered output
  status_read_a: assert property (rd_active && cmd_eff |-> !host_data_oe_n ##1
    host_data_out == $past(status))
    else $error("status read returned wrong byte");
  obf_pin_a: assert property (flags_mode_q && port2_latch_q[0] |=>
    port2_upper[0] == $past(obf_q))
    else $error("output full pin does not follow status");
  ibf_pin_a: assert property (flags_mode_q && !port2_latch_q[1] |=> !port2_upper[1])
    else $error("disabled input full pin not held low");
  drq_drop_a: assert property (drq_q && dma_acknowledge_done && !port2_wr |=> !drq_q ##1 !port2_upper[2])
    else $error("dma request not withdrawn on acknowledge");
  reset_modes_a: assert property (disable iff (1'b0) reset |=>
    !flags_mode_q && !dma_mode_q && status == 8'h00)
    else $error("reset did not restore port pins and status");
endmodule

// File: testbench/shbi_master_model.sv
// master cpu and dma controller model driving the host strobes
`timescale 1ns/1ps
module shbi_master_model (
  // clock
  input wire logic clk,
  // host bus and dma acknowledge pins
  output shbi_pkg::shbi_host_in_t host_in,
  output logic dma_acknowledge_n,
  // device read data
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe_n
);
  // idle bus: strobes high, nothing selected
  initial begin
    host_in = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h5A};
    dma_acknowledge_n = 1'b1;
  end
  // one strobe, low for one cycle; selects and data held until the strobe has risen
  task automatic xfer(input bit wr, input bit cs, input bit dk, input logic a0,
                      input logic [7:0] wd, output logic [7:0] rd, output logic oe_n);
    @(posedge clk);
    #1;
    host_in.cs_n = !cs;
    dma_acknowledge_n = !dk;
    host_in.command_select = a0;
    if (wr) host_in.data = wd;
    if (wr) host_in.wr_n = 1'b0;
    else host_in.rd_n = 1'b0;
    #1 oe_n = host_data_oe_n;
    @(posedge clk);
    #1;
    rd = host_data_out;
    host_in.wr_n = 1'b1;
    host_in.rd_n = 1'b1;
    @(posedge clk);
    #1;
    host_in.cs_n = 1'b1;
    dma_acknowledge_n = 1'b1;
    // released bus flips so a stale value can never look valid
    host_in.data = ~host_in.data;
  endtask
endmodule

// File: testbench/shbi_host_port_test.sv
// self-checking bench for the slave host bus interface
`timescale 1ns/1ps
module shbi_host_port_test;
  logic clk;
  logic reset;
  shbi_pkg::shbi_host_in_t host_in;
  shbi_pkg::shbi_instr_t instr;
  logic [7:0] host_data_out, out_buf_data, in_buf_data, status;
  logic host_data_oe_n, in_buf_rd, out_buf_wr, flag_wr, flag_f0, flag_f1, ibf_int;
  logic port2_wr, dma_acknowledge_n;
  logic [3:0] port2_wdata, port2_upper;
  int err_count, tests_run, exp_int, int_seen;
  int m_obf, m_ibf, m_f0, m_f1, m_user, m_inb, m_outb, m_latch, m_flags, m_dma, m_drq;

  shbi_host_port u_shbi_host_port (.clk(clk), .reset(reset), .host_in(host_in),
    .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n), .instr(instr),
    .in_buf_rd(in_buf_rd), .out_buf_wr(out_buf_wr), .out_buf_data(out_buf_data),
    .flag_wr(flag_wr), .flag_f0(flag_f0), .flag_f1(flag_f1), .in_buf_data(in_buf_data),
    .status(status), .ibf_int(ibf_int), .port2_wr(port2_wr), .port2_wdata(port2_wdata),
    .port2_bit7_in(dma_acknowledge_n), .port2_upper(port2_upper));
  shbi_master_model u_shbi_master_model (.clk(clk), .host_in(host_in), .dma_acknowledge_n(dma_acknowledge_n),
    .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count interrupt pulses seen by the core
  always @(posedge clk) begin
    if (ibf_int === 1'b1) int_seen++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] exp_status();
    return {4'(m_user), 1'(m_f1), 1'(m_f0), 1'(m_ibf), 1'(m_obf)};
  endfunction
  // bit7 is the acknowledge input in dma mode, so it is left out there
  task automatic check_all();
    logic [3:0] p;
    logic [3:0] mask;
    p[0] = m_flags ? (m_latch[0] && m_obf) : m_latch[0];
    p[1] = m_flags ? (m_latch[1] && !m_ibf) : m_latch[1];
    p[2] = m_dma ? m_drq[0] : m_latch[2];
    p[3] = m_latch[3];
    mask = m_dma ? 4'h7 : 4'hF;
    check("status", exp_status(), status);
    check("in_buf", 8'(m_inb), in_buf_data);
    check("pins", {4'h0, p & mask}, {4'h0, port2_upper & mask});
  endtask
  task automatic host(input bit wr, input bit cs, input bit dk, input bit a0, input int wd);
    logic [7:0] rd, st;
    logic oe;
    bit sel, cmd;
    sel = cs | dk;
    cmd = a0 & !dk;
    st = exp_status();
    u_shbi_master_model.xfer(wr, cs, dk, a0, 8'(wd), rd, oe);
    if (!wr) check("oe_n", {7'h0, !sel}, {7'h0, oe});
    if (!wr && sel) check("rdata", cmd ? st : 8'(m_outb), rd);
    if (wr && sel) begin
      m_ibf = 1;
      m_inb = wd & 255;
      m_f1 = cmd;
      exp_int++;
    end
    if (!wr && sel && !cmd) m_obf = 0;
    if (dk) m_drq = 0;
    tick(2);
    check_all();
    check("ints", 8'(exp_int), 8'(int_seen));
  endtask
  // kinds: 0 read in, 1 load out, 2 flags, 3 port2, 4 user status, 5 flag pins, 6 dma
  task automatic core(input int kind, input int v);
    case (kind)
      0: begin in_buf_rd = 1'b1; m_ibf = 0; end
      1: begin out_buf_wr = 1'b1; out_buf_data = 8'(v); m_obf = 1; m_outb = v & 255; end
      2: begin flag_wr = 1'b1; {flag_f1, flag_f0} = 2'(v); m_f0 = v & 1; m_f1 = v[1]; end
      3: begin port2_wr = 1'b1; port2_wdata = 4'(v); m_latch = v & 15; end
      4: begin instr = '{1'b1, shbi_pkg::SHBI_OP_LOAD_USER_STATUS, 8'(v)}; m_user = v[7:4]; end
      5: begin instr = '{1'b1, shbi_pkg::SHBI_OP_ENABLE_FLAGS, 8'(v)}; m_flags = 1; end
      default: begin instr = '{1'b1, shbi_pkg::SHBI_OP_ENABLE_DMA, 8'(v)}; m_drq = 0; end
    endcase
    if (kind == 3 && m_dma && v[2]) m_drq = 1;
    if (kind == 6) m_dma = 1;
    tick(1);
    {in_buf_rd, out_buf_wr, flag_wr, port2_wr} = 4'h0;
    instr = '0;
    tick(2);
    check_all();
  endtask
  task automatic do_reset();
    reset = 1'b1;
    tick(10);
    reset = 1'b0;
    {m_obf, m_ibf, m_f0, m_f1, m_user, m_inb, m_outb, m_flags, m_dma, m_drq} = '0;
    m_latch = 15;
    check_all();
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded run: a hang ends as a failure
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    // only reset starts high; the core strobes must idle low or they act on release
    {reset, in_buf_rd, out_buf_wr, flag_wr, flag_f0, flag_f1, port2_wr} = 7'h40;
    {instr, out_buf_data, port2_wdata} = '0;
    void'($urandom(32'h00341d98));
    tick(1);
    do_reset();
    for (int i = 0; i < 4; i++) begin
      host(1, 1, 0, $urandom % 2, $urandom);
      host(1, 1, 0, i % 2, $urandom);
      core(0, 0);
      core(1, $urandom);
      host(0, 1, 0, 1, 0);
      host(0, 1, 0, 0, 0);
    end
    host(1, 0, 0, 0, 8'hC3);
    host(0, 0, 0, 1, 0);
    core(4, $urandom);
    core(4, 8'h9F);
    core(2, 3);
    core(2, 1);
    core(3, 5);
    core(5, 0);
    core(3, 3);
    core(1, 8'hA5);
    host(1, 1, 0, 0, 8'h3C);
    core(0, 0);
    core(3, 0);
    core(6, 0);
    core(3, 4'hF);
    host(0, 0, 1, 1, 0);
    core(3, 4'hC);
    host(1, 0, 1, 1, $urandom);
    core(3, 4'hC);
    core(6, 0);
    do_reset();
    final_report();
  end
endmodule
